// File: bench/ccsd_assertions.sv
// Port checker for ccsd_top: divider period, deep-stop, accuracy, slow tree.
// Assumes one core_clock domain; bound to every ccsd_top instance.
`timescale 1ns/1ns
module ccsd_checker
    import ccsd_pkg::*;
(
    input wire logic       core_clock,
    input wire logic       rst_n,
    input wire logic [1:0] rootSelect,
    input wire logic       xoDirectSelect,
    input wire logic [2:0] coreClockDivider,
    input wire logic [1:0] slowSelect,
    input wire logic       slowRcTick,
    input wire logic       deepStopReq,
    input wire logic       rootTick,
    input wire logic       coreClockEn,
    input wire logic       slowClockEn,
    input wire logic       rootAccurate,
    input wire logic       fastBlockOn,
    input wire logic       deepStopped,
    input wire logic       deepStopRefused,
    input wire logic [2:0] activeDivider
);
    default clocking @(posedge core_clock); endclocking
    default disable iff (!rst_n);
    int   cnt_reg;
    logic xoLat_reg;
    // Direct-select is taken at the wrap, so the period's ratio pairs it with the applied code
    function automatic int rat(logic [2:0] c, logic x);
        return c < 2 ? c + 1 : (x ? 3 : 4) << (c - 2);
    endfunction : rat
    always_ff @(posedge core_clock) begin
        if (!rst_n || coreClockEn) cnt_reg <= 0;
        else if (rootTick) cnt_reg <= cnt_reg + 1;
        if (!rst_n) xoLat_reg <= 1'b0;
        else if (coreClockEn) xoLat_reg <= xoDirectSelect;
    end
    property p_ratio; rootTick || coreClockEn |-> rootTick && coreClockEn == (cnt_reg + 1 == rat(activeDivider, xoLat_reg)); endproperty
    a_ratio: assert property (p_ratio) else $error("core enable off its period");
    property p_rst; $rose(rst_n) |-> activeDivider == DIV_RESET; endproperty
    a_rst: assert property (p_rst) else $error("divider not at reset code");
    property p_keep; coreClockDivider == DIV_RESERVED |=> $stable(activeDivider); endproperty
    a_keep: assert property (p_keep) else $error("reserved code applied");
    property p_acc; $past(rst_n) && rootSelect == ROOT_XO && $past(rootSelect) == ROOT_XO |-> rootAccurate; endproperty
    a_acc: assert property (p_acc) else $error("crystal root not accurate");
    property p_ref; $past(rst_n) && $rose(deepStopReq) && rootSelect == ROOT_XO && $past(rootSelect) == ROOT_XO && !deepStopped |=> deepStopRefused && !deepStopped; endproperty
    a_ref: assert property (p_ref) else $error("stop on crystal not refused");
    property p_stop; $rose(deepStopReq) && rootSelect == ROOT_RC && $past(rootSelect) == ROOT_RC && !deepStopped |-> ##2 deepStopped; endproperty
    a_stop: assert property (p_stop) else $error("stop not entered");
    property p_off; fastBlockOn != deepStopped && !(deepStopped && rootTick); endproperty
    a_off: assert property (p_off) else $error("clock runs in stop");
    property p_slow; $past(rst_n) && slowSelect == SLOW_RC && $past(slowSelect) == SLOW_RC |=> slowClockEn == $past(slowRcTick); endproperty
    a_slow: assert property (p_slow) else $error("slow enable not from slow rc");
endmodule : ccsd_checker
bind ccsd_top ccsd_checker u_chk (.*);

// File: bench/ccsd_tb_top.sv
// Bench for ccsd_top: ratios, reserved code, accuracy, deep-stop, slow tree.
// Assumes 25 MHz core_clock; fast source ticks held high so the root ticks every cycle.
`timescale 1ns/1ns
module ccsd_tb_top;
    import ccsd_pkg::*;
    logic       core_clock = 0, rst_n = 0, fastRcTick = 1, pllTick = 1, xoTick = 1, xoIsClockInput = 0, pllLocked = 0;
    logic       slowRcTick = 0, slowXoTick = 0, xoDirectSelect = 0, deepStopReq = 0, wakeup = 0;
    logic [1:0] rootSelect = 0, slowSelect = 0;
    logic [2:0] coreClockDivider = 3'h2, activeDivider;
    logic       rootTick, coreClockEn, slowClockEn, rootAccurate, fastBlockOn, deepStopped, deepStopRefused;
    int         n_mismatch = 0, samples_checked = 0, n;
    ccsd_top uut (.*);
    initial forever #20 core_clock = ~core_clock;
    task automatic chk(string s, logic [6:0] e, logic [6:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", s, e, g);
        end
    endtask : chk
    // Skip one partial period, then count edges between two enables
    task automatic per;
        for (int i = 0; i < 200 && coreClockEn !== 1'b1; i++) @(negedge core_clock);
        n = 0;
        do begin
            @(negedge core_clock);
            n++;
        end while (coreClockEn !== 1'b1 && n < 200);
    endtask : per
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    // ==========
    // Tests
    initial begin
        repeat (3) @(posedge core_clock);
        rst_n <= 1;
        @(negedge core_clock);
        chk("divider", DIV_RESET, 7'(activeDivider));
        per;
        per;
        chk("reset ratio", 7'h4, 7'(n));
        $display("reset test done");
        for (int c = 0; c < 14; c++) begin
            @(posedge core_clock);
            coreClockDivider <= c[3:1];
            xoDirectSelect <= c[0];
            per;
            per;
            chk("ratio", 7'(c < 4 ? c / 2 + 1 : (c[0] ? 3 : 4) << (c / 2 - 2)), 7'(n));
        end
        @(posedge core_clock);
        coreClockDivider <= DIV_RESERVED;
        per;
        per;
        chk("reserved ratio", 7'h30, 7'(n));
        chk("kept code", 7'h6, 7'(activeDivider));
        $display("divider test done");
        for (int c = 0; c < 6; c++) begin
            @(posedge core_clock);
            rootSelect <= 2'(c / 2);
            pllLocked <= c[0];
            xoIsClockInput <= c[0];
            fastRcTick <= c / 2 == 0;
            pllTick <= c / 2 == 1;
            xoTick <= c / 2 == 2;
            @(posedge core_clock);
            @(negedge core_clock);
            chk("accurate", 7'(c >= 3), 7'(rootAccurate));
            chk("root tick", 7'h1, 7'(rootTick));
        end
        @(posedge core_clock);
        fastRcTick <= 1;
        pllTick <= 1;
        xoTick <= 1;
        $display("root test done");
        @(posedge core_clock);
        deepStopReq <= 1;
        @(posedge core_clock);
        deepStopReq <= 0;
        @(negedge core_clock);
        chk("refused", 7'h1, 7'(deepStopRefused));
        @(posedge core_clock);
        rootSelect <= ROOT_RC;
        repeat (2) @(posedge core_clock);
        deepStopReq <= 1;
        @(posedge core_clock);
        deepStopReq <= 0;
        repeat (2) @(posedge core_clock);
        @(negedge core_clock);
        chk("stopped", 7'h1, 7'(deepStopped));
        chk("fast block", 7'h0, 7'(fastBlockOn));
        @(posedge core_clock);
        wakeup <= 1;
        @(posedge core_clock);
        wakeup <= 0;
        @(posedge core_clock);
        @(negedge core_clock);
        chk("woken", 7'h0, 7'(deepStopped));
        $display("stop test done");
        for (int c = 0; c < 2; c++) begin
            @(posedge core_clock);
            slowSelect <= 2'(c);
            @(posedge core_clock);
            slowRcTick <= c == 0;
            slowXoTick <= c == 1;
            @(posedge core_clock);
            slowRcTick <= 0;
            slowXoTick <= 0;
            @(negedge core_clock);
            chk("slow tick", 7'h1, 7'(slowClockEn));
        end
        @(posedge core_clock);
        slowSelect <= SLOW_ROOT;
        n = 0;
        repeat (1024) begin
            @(negedge core_clock);
            if (slowClockEn === 1'b1) n++;
        end
        chk("slow root", 7'h2, 7'(n));
        $display("slow test done");
        finish_test;
    end
    // Run needs about 2000 cycles; the limit allows 20000
    initial begin
        #800000;
        n_mismatch++;
        finish_test;
    end
endmodule : ccsd_tb_top

// File: verilog/ccsd_pkg.sv
// Constants for the core clock select and divide block.
// Assumes one system clock core_clock; clock sources arrive as enable pulses.
// Function
// - Root clock comes from internal fast RC, crystal-locked PLL, or external fast source.
// - External fast source may be a crystal or single-ended clock input.
// - Slow clock selects internal slow RC, external slow source, or root divided by 512.
// - Internal slow RC runs fixed 24 to 49 kHz, treated as 32 kHz.
// - Root-derived slow clock is unavailable in deep-stop mode.
// - Fast RC/PLL block is accurate only once its PLL has locked.
// - After reset the core clock divider defaults to divide-by-four.
// - Code 000 passes, 001 halves, 010 divides by 4 or 3.
// - Codes 011 to 110 divide by 8..64 or 6..48.
// - Deep-stop stops core clock and needs fast RC/PLL as source.
package ccsd_pkg;
    localparam logic [2:0] DIV_RESET    = 3'h2;
    localparam logic [2:0] DIV_RESERVED = 3'h7;
    localparam logic [1:0] ROOT_RC      = 2'h0;
    localparam logic [1:0] ROOT_PLL     = 2'h1;
    localparam logic [1:0] ROOT_XO      = 2'h2;
    localparam logic [1:0] SLOW_RC      = 2'h0;
    localparam logic [1:0] SLOW_XO      = 2'h1;
    localparam logic [1:0] SLOW_ROOT    = 2'h2;
    localparam logic [8:0] SLOW_DIV_LAST = 9'h1FF;
    localparam int         RATIO_W      = 7;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_ENTER = 2'b01,
        ST_STOP  = 2'b11
    } ccsd_state_t;
endpackage : ccsd_pkg

// File: verilog/ccsd_ratio.sv
// Ratio lookup for the core clock divider.
// Assumes code and direct-select are registered by the caller.
`timescale 1ns/1ns
module ccsd_ratio
    import ccsd_pkg::*;
(
    input  wire logic [2:0]         divCode,    // Divider code
    input  wire logic               xoDirect,   // Direct crystal select
    output logic      [RATIO_W-1:0] ratio       // Division ratio
);
    always_comb begin
        case (divCode)
            3'h0:    ratio = 7'd1;
            3'h1:    ratio = 7'd2;
            3'h2:    ratio = xoDirect ? 7'd3  : 7'd4;
            3'h3:    ratio = xoDirect ? 7'd6  : 7'd8;
            3'h4:    ratio = xoDirect ? 7'd12 : 7'd16;
            3'h5:    ratio = xoDirect ? 7'd24 : 7'd32;
            3'h6:    ratio = xoDirect ? 7'd48 : 7'd64;
            default: ratio = 7'd4;
        endcase
    end
endmodule : ccsd_ratio

// File: verilog/ccsd_top.sv
// Core clock source select and divider, producing enable pulses.
// Assumes clock sources arrive as one-cycle ticks synchronous to core_clock.
`timescale 1ns/1ns
module ccsd_top
    import ccsd_pkg::*;
(
    input  wire logic       core_clock,           // System clock
    input  wire logic       rst_n,             // Sync reset, active low
    input  wire logic       fastRcTick,        // internal_fast_rc edge tick
    input  wire logic       pllTick,           // xo_locked_pll edge tick
    input  wire logic       xoTick,            // external_fast_xo edge tick
    input  wire logic       xoIsClockInput,    // XO fed by single-ended clock
    input  wire logic       pllLocked,         // PLL lock from analog block
    input  wire logic       slowRcTick,        // internal_slow_rc tick
    input  wire logic       slowXoTick,        // external_slow_xo tick
    input  wire logic [1:0] rootSelect,        // Root source select
    input  wire logic       xoDirectSelect,    // xo_direct_select
    input  wire logic [2:0] coreClockDivider,  // core_clock_divider code
    input  wire logic [1:0] slowSelect,        // Slow tree source select
    input  wire logic       deepStopReq,       // Deep-stop entry request
    input  wire logic       wakeup,            // Deep-stop exit
    output logic            rootTick,          // Root clock tick
    output logic            coreClockEn,       // core_clock enable pulse
    output logic            slowClockEn,       // Slow tree enable pulse
    output logic            rootAccurate,      // Root clock is crystal-accurate
    output logic            fastBlockOn,       // fast_rc_pll_block power
    output logic            deepStopped,       // Deep-stop active
    output logic            deepStopRefused,   // Entry refused, wrong source
    output logic [2:0]      activeDivider      // Applied divider code
);
    // =========================================================
    // Declarations
    logic [1:0]         rootSel_reg;       // Applied root source
    logic [1:0]         rootSel_next;
    logic [2:0]         divCode_reg;       // Applied divider code
    logic [2:0]         divCode_next;
    logic               xoDirect_reg;      // Applied direct-crystal select
    logic               xoDirect_next;
    logic [RATIO_W-1:0] ratio;             // Ratio of the applied code
    logic [RATIO_W-1:0] divCnt_reg;        // Root ticks into the period
    logic [RATIO_W-1:0] divCnt_next;
    logic [8:0]         slowCnt_reg;       // Root ticks for the slow tree
    logic [8:0]         slowCnt_next;
    logic               slowClockEn_next;
    ccsd_state_t        state_reg;         // Deep-stop sequencer
    ccsd_state_t        state_next;
    logic               refused_next;
    logic               rootRaw;
    logic               rootGate;
    logic               divWrap;
    logic               periodEnd;
    logic               slowRootTick;

    // =========================================================
    // Root selection
    // Source changes are frozen outside RUN so the stop sequence sees one source
    always_comb begin
        rootSel_next = rootSel_reg;
        if (state_reg == ST_RUN && rootSelect != 2'h3) begin
            rootSel_next = rootSelect;
        end
    end

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            rootSel_reg <= ROOT_RC;
        end else begin
            rootSel_reg <= rootSel_next;
        end
    end

    // XO crystal or single-ended input look identical as ticks
    always_comb begin
        case (rootSel_reg)
            ROOT_RC:  rootRaw = fastRcTick;
            ROOT_PLL: rootRaw = pllTick;
            ROOT_XO:  rootRaw = xoTick;
            default:  rootRaw = fastRcTick;
        endcase
    end

    // Fast block is off in deep-stop, so its ticks vanish; XO reaches stop only if selected on the entry cycle
    assign rootGate     = fastBlockOn || (rootSel_reg == ROOT_XO);
    assign rootTick     = rootRaw && rootGate;
    assign rootAccurate = (rootSel_reg == ROOT_XO) ||
                          (rootSel_reg == ROOT_PLL && pllLocked);
    assign fastBlockOn  = (state_reg != ST_STOP);
    assign deepStopped  = (state_reg == ST_STOP);

    // =========================================================
    // Divider
    // A new ratio is taken only at the end of a period, so no pulse is cut short
    assign divWrap   = (divCnt_reg >= ratio - 7'd1);
    assign periodEnd = rootTick && divWrap;

    always_comb begin
        divCode_next  = divCode_reg;
        xoDirect_next = xoDirect_reg;
        if (periodEnd) begin
            if (coreClockDivider != DIV_RESERVED) begin
                divCode_next = coreClockDivider;
            end
            xoDirect_next = xoDirectSelect;
        end
    end

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            divCode_reg  <= DIV_RESET;
            xoDirect_reg <= 1'b0;
        end else begin
            divCode_reg  <= divCode_next;
            xoDirect_reg <= xoDirect_next;
        end
    end

    ccsd_ratio uRatio (
        .divCode  (divCode_reg),
        .xoDirect (xoDirect_reg),
        .ratio    (ratio)
    );

    always_comb begin
        divCnt_next = divCnt_reg;
        if (rootTick) begin
            if (divWrap) begin
                divCnt_next = '0;
            end else begin
                divCnt_next = divCnt_reg + 7'd1;
            end
        end
    end

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            divCnt_reg <= '0;
        end else begin
            divCnt_reg <= divCnt_next;
        end
    end

    // Gated in stop as well, since an XO root selected on the entry cycle still ticks there
    assign coreClockEn   = periodEnd && !deepStopped;
    assign activeDivider = divCode_reg;

    // =========================================================
    // Slow tree
    // Free-running from reset; its phase is not tied to the core divider
    always_comb begin
        slowCnt_next = slowCnt_reg;
        if (rootTick) begin
            slowCnt_next = slowCnt_reg + 9'd1;
        end
    end

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            slowCnt_reg <= '0;
        end else begin
            slowCnt_reg <= slowCnt_next;
        end
    end

    // Root-derived slow tick dies in deep-stop; stop-time users need RC or XO
    assign slowRootTick = rootTick && (slowCnt_reg == SLOW_DIV_LAST) && !deepStopped;

    // RC accuracy is whatever the part gives; no trimming here
    always_comb begin
        case (slowSelect)
            SLOW_RC:   slowClockEn_next = slowRcTick;
            SLOW_XO:   slowClockEn_next = slowXoTick;
            SLOW_ROOT: slowClockEn_next = slowRootTick;
            default:   slowClockEn_next = 1'b0;
        endcase
    end

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            slowClockEn <= 1'b0;
        end else begin
            slowClockEn <= slowClockEn_next;
        end
    end

    // =========================================================
    // Deep-stop sequencing
    // Entry only from a fast RC/PLL root, since stop powers that block down
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (deepStopReq && rootSel_reg != ROOT_XO) begin
                    state_next = ST_ENTER;
                end
            end
            ST_ENTER: begin
                state_next = ST_STOP;
            end
            ST_STOP: begin
                if (wakeup) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign refused_next = deepStopReq && (state_reg == ST_RUN) && (rootSel_reg == ROOT_XO);

    always_ff @(posedge core_clock) begin
        if (!rst_n) begin
            deepStopRefused <= 1'b0;
        end else begin
            deepStopRefused <= refused_next;
        end
    end

    // Crystal or single-ended input needs no different handling here
    logic unusedIn;
    assign unusedIn = xoIsClockInput;
endmodule : ccsd_top
